// [rtl/kseg_tlb_pkg.sv]
// Shared constants, types and field layouts for the kernel segment decoder and translation registers.
package kseg_tlb_pkg;

    // Translation buffer geometry.
    localparam int TLB_ENTRIES = 32;
    localparam int SLOT_W = 5;
    localparam int PAGE_SHIFT = 10;
    localparam int VPN2_W = 29;
    localparam int PFN_W = 23;
    localparam int SPACE_ID_W = 8;

    // Register numbers on the coprocessor register port.
    localparam logic [4:0] REG_SLOT_POINTER = 5'h00;
    localparam logic [4:0] REG_REPLACE_POINTER = 5'h01;
    localparam logic [4:0] REG_EVEN_ENTRY_LOW = 5'h02;
    localparam logic [4:0] REG_ODD_ENTRY_LOW = 5'h03;
    localparam logic [4:0] REG_BOUNDARY = 5'h06;

    // Field positions of the entry-low registers and the slot pointer probe flag.
    localparam int LO_PFN_MSB = 28;
    localparam int LO_PFN_LSB = 6;
    localparam int LO_ALGO_MSB = 5;
    localparam int LO_ALGO_LSB = 3;
    localparam int LO_DIRTY_BIT = 2;
    localparam int LO_VALID_BIT = 1;
    localparam int LO_GLOBAL_BIT = 0;
    localparam int PROBE_FAIL_BIT = 31;

    // Writable masks; bits outside them read as zero, except the slot pointer probe flag in bit 31.
    localparam logic [31:0] LO_WR_MASK = 32'h1fff_ffff;
    localparam logic [31:0] SLOT_WR_MASK = 32'h0000_001f;

    // Reset values and the replacement pointer reload value.
    localparam logic [4:0] REPLACE_RESET = 5'h1f;
    localparam logic [4:0] BOUNDARY_RESET = 5'h00;
    localparam logic [4:0] REPLACE_UPPER = 5'h1f;

    // Cache algorithm code meaning uncached.
    localparam logic [2:0] ALGO_UNCACHED = 3'h2;

    // Address space region codes held in bits 63 and 62.
    localparam logic [1:0] REGION_USER = 2'h0;
    localparam logic [1:0] REGION_SUPER = 2'h1;
    localparam logic [1:0] REGION_PHYS = 2'h2;
    localparam logic [1:0] REGION_KERNEL = 2'h3;

    // One page half of a translation entry.
    typedef struct packed {
        logic [PFN_W-1:0] page_frame_number;
        logic [2:0] cache_algo;
        logic dirty;
        logic valid;
    } page_half_s;

    // Upper half of an entry as presented by the pipeline.
    typedef struct packed {
        logic [1:0] region;
        logic [VPN2_W-1:0] vpn2;
        logic [SPACE_ID_W-1:0] space_id;
    } entry_high_s;

    // One whole translation entry.
    typedef struct packed {
        entry_high_s high;
        logic global_page;
        page_half_s [1:0] half;
    } tlb_entry_s;

    // Result of the segment decode.
    typedef struct packed {
        logic mapped;
        logic cached;
        logic [31:0] paddr;
        logic addr_error;
        logic tlb_refill;
        logic invalid_load;
        logic invalid_store;
        logic write_protect;
    } xlate_s;

    // Whole register state of the block.
    typedef struct packed {
        tlb_entry_s [TLB_ENTRIES-1:0] entry;
        logic [31:0] slot_pointer;
        logic [4:0] replace_pointer;
        logic [4:0] boundary;
        logic [31:0] even_entry_low;
        logic [31:0] odd_entry_low;
        logic [31:0] read_data;
        logic read_valid;
        entry_high_s read_high;
    } state_s;

endpackage : kseg_tlb_pkg

// [rtl/kernel_segment_decode_tlb_regs.sv]
// Kernel segment decoder with translation buffer and its management registers.
//
// Summary of operation
// - 32-bit 110 selects mapped supervisor window.
// - 32-bit 111 selects mapped kernel window three.
// - 64-bit region 00 selects mapped user window.
// - Error level makes low 2 Gbytes unmapped uncached.
// - 64-bit region 01 selects mapped supervisor window.
// - Region 10 unmapped; bits 58-32 set error.
// - Bits 61-59 give cacheability, low 32 address.
// - Region 11 translates through buffer with identifier.
// - All-ones 61-31 picks compatibility window by 30-29.
// - Compat window zero unmapped, kernel algorithm field.
// - Compat window one unmapped and uncached.
// - Compat windows two, three mapped, entry cacheability.
// - Physical addresses are 32 bits wide.
// - Buffer holds 32 entries, 5-bit slot number.
// - Slot pointer low five bits select entry.
// - Probe failure sets top bit, success clears.
// - Replacement pointer decrements between boundary and 31.
// - Replacement pointer reloads 31 on reset, boundary write.
// - Reserved fields read back as zero.
// - Entry-low registers hold even and odd halves.
// - Invalid matched page raises load or store fault.
// - Dirty bit clear means page is write-protected.
// - Global in both halves ignores space identifier.
// - Algorithm code 010 uncached, others cached.
// - Boundary resets zero; protects entries from random writes.
`timescale 1ns/1ps
`default_nettype none

module kernel_segment_decode_tlb_regs
    import kseg_tlb_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Status bits from the core.
    input wire logic wide_kernel_addressing_i,
    input wire logic error_level_flag_i,
    input wire logic [2:0] kernel_window_cache_algo_i,
    // Address presented by the load/store or fetch path.
    input wire logic access_valid_i,
    input wire logic access_store_i,
    input wire logic [63:0] vaddr_i,
    input wire logic [SPACE_ID_W-1:0] space_identifier_i,
    // Buffer management instructions and the upper entry half they use.
    input wire logic probe_instruction_i,
    input wire logic indexed_read_instruction_i,
    input wire logic indexed_write_instruction_i,
    input wire logic random_write_instruction_i,
    input wire entry_high_s entry_high_i,
    input wire logic instr_retire_i,
    // Coprocessor register port.
    input wire logic [4:0] reg_num_i,
    input wire logic reg_write_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Upper half returned by an indexed read.
    output entry_high_s read_high_o,
    // Translation result.
    output xlate_s xlate_o
);

    state_s state_reg;
    state_s state_next;
    logic [63:0] eff_va;
    logic [TLB_ENTRIES-1:0] xlate_hit_vec;
    logic [TLB_ENTRIES-1:0] probe_hit_vec;
    logic xlate_hit;
    logic [SLOT_W-1:0] xlate_slot;
    logic probe_hit;
    logic [SLOT_W-1:0] probe_slot;
    page_half_s hit_half;
    tlb_entry_s new_entry;

    // True unless the algorithm code marks the page uncached.
    function automatic logic algo_cached(input logic [2:0] algo);
        return algo != ALGO_UNCACHED;
    endfunction : algo_cached

    // Compares one entry against a region, page pair number and identifier.
    function automatic logic entry_match(input tlb_entry_s e, input logic [1:0] region,
                                         input logic [VPN2_W-1:0] vpn2, input logic [SPACE_ID_W-1:0] sid);
        return (e.high.region == region) && (e.high.vpn2 == vpn2) &&
               (e.global_page || (e.high.space_id == sid));
    endfunction : entry_match

    // Splits an entry-low register into its page fields.
    function automatic page_half_s low_to_half(input logic [31:0] low);
        page_half_s h;
        h.page_frame_number = low[LO_PFN_MSB:LO_PFN_LSB];
        h.cache_algo = low[LO_ALGO_MSB:LO_ALGO_LSB];
        h.dirty = low[LO_DIRTY_BIT];
        h.valid = low[LO_VALID_BIT];
        return h;
    endfunction : low_to_half

    // Packs page fields back into entry-low layout, reserved bits zero.
    function automatic logic [31:0] half_to_low(input page_half_s h, input logic g);
        logic [31:0] low;
        low = 32'h0000_0000;
        low[LO_PFN_MSB:LO_PFN_LSB] = h.page_frame_number;
        low[LO_ALGO_MSB:LO_ALGO_LSB] = h.cache_algo;
        low[LO_DIRTY_BIT] = h.dirty;
        low[LO_VALID_BIT] = h.valid;
        low[LO_GLOBAL_BIT] = g;
        return low;
    endfunction : half_to_low

    // In 32-bit mode the address is sign-extended from bit 31.
    assign eff_va = wide_kernel_addressing_i ? vaddr_i : {{32{vaddr_i[31]}}, vaddr_i[31:0]};

    // entry compare
    // Each of the 32 entries is compared against the access and the probe.
    // Both compares run side by side, so a probe never stalls translation.
    genvar gi;
    generate
        for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_match
            assign xlate_hit_vec[gi] = entry_match(state_reg.entry[gi], eff_va[63:62],
                                                   eff_va[39:PAGE_SHIFT+1], space_identifier_i);
            assign probe_hit_vec[gi] = entry_match(state_reg.entry[gi], entry_high_i.region,
                                                   entry_high_i.vpn2, entry_high_i.space_id);
        end
    endgenerate

    // Picks the lowest matching slot for translation and for the probe.
    // Two hits are a software fault; the lowest slot keeps the answer defined.
    always_comb begin
        xlate_hit = 1'b0;
        xlate_slot = '0;
        probe_hit = 1'b0;
        probe_slot = '0;
        for (int i = TLB_ENTRIES - 1; i >= 0; i--) begin
            if (xlate_hit_vec[i]) begin
                xlate_hit = 1'b1;
                xlate_slot = SLOT_W'(i);
            end
            if (probe_hit_vec[i]) begin
                probe_hit = 1'b1;
                probe_slot = SLOT_W'(i);
            end
        end
    end

    // The odd or even page of the matched pair is chosen by the bit above the offset.
    // A miss reads slot zero here; only the refill flag tells it apart.
    assign hit_half = state_reg.entry[xlate_slot].half[eff_va[PAGE_SHIFT]];

    // entry from low halves
    // Entry image built from the staged halves and the presented upper half.
    always_comb begin
        new_entry.high = entry_high_i;
        new_entry.half[0] = low_to_half(state_reg.even_entry_low);
        new_entry.half[1] = low_to_half(state_reg.odd_entry_low);
        new_entry.global_page = state_reg.even_entry_low[LO_GLOBAL_BIT] & state_reg.odd_entry_low[LO_GLOBAL_BIT];
    end

    // combinational decode
    // Classifies the address into its window, the same cycle it is presented.
    always_comb begin
        xlate_o = '0;
        xlate_o.paddr = eff_va[31:0];
        // Narrow mode looks only at the low word of the address.
        if (!wide_kernel_addressing_i) begin
            case (vaddr_i[31:29])
                3'b100: begin
                    xlate_o.cached = algo_cached(kernel_window_cache_algo_i);
                    xlate_o.paddr = {3'h0, vaddr_i[28:0]};
                end
                3'b101: begin
                    xlate_o.paddr = {3'h0, vaddr_i[28:0]};
                end
                3'b110: xlate_o.mapped = 1'b1;
                3'b111: xlate_o.mapped = 1'b1;
                default: begin
                    xlate_o.mapped = !error_level_flag_i;
                end
            endcase
        end else begin

            // Wide mode: the two top bits choose the region.
            case (vaddr_i[63:62])
                REGION_USER: begin
                    if (error_level_flag_i && (vaddr_i[63:31] == 33'h0)) begin
                        xlate_o.mapped = 1'b0;
                    end else if (|vaddr_i[61:40]) begin
                        xlate_o.addr_error = 1'b1;
                    end else begin
                        xlate_o.mapped = 1'b1;
                    end
                end

                REGION_SUPER: begin
                    if (|vaddr_i[61:40]) begin
                        xlate_o.addr_error = 1'b1;
                    end else begin
                        xlate_o.mapped = 1'b1;
                    end
                end

                REGION_PHYS: begin
                    xlate_o.addr_error = |vaddr_i[58:32];
                    xlate_o.cached = algo_cached(vaddr_i[61:59]);
                    xlate_o.paddr = vaddr_i[31:0];
                end

                REGION_KERNEL: begin
                    if (&vaddr_i[61:31]) begin
                        case (vaddr_i[30:29])
                            2'b00: begin
                                xlate_o.cached = algo_cached(kernel_window_cache_algo_i);
                                xlate_o.paddr = {3'h0, vaddr_i[28:0]};
                            end
                            2'b01: begin
                                xlate_o.paddr = {3'h0, vaddr_i[28:0]};
                            end
                            default: xlate_o.mapped = 1'b1;
                        endcase
                    end else if ((|vaddr_i[61:40]) || (&vaddr_i[39:31])) begin
                        xlate_o.addr_error = 1'b1;
                    end else begin
                        xlate_o.mapped = 1'b1;
                    end
                end
                default: xlate_o.addr_error = 1'b1;
            endcase
        end

        // Mapped windows take frame, cacheability and faults from the matched page.
        // Faults need a presented access, so an idle address raises none.
        if (xlate_o.mapped) begin
            xlate_o.paddr = {hit_half.page_frame_number[21:0], eff_va[PAGE_SHIFT-1:0]};
            xlate_o.cached = xlate_hit && algo_cached(hit_half.cache_algo);
            if (access_valid_i) begin
                xlate_o.tlb_refill = !xlate_hit;
                xlate_o.invalid_load = xlate_hit && !hit_half.valid && !access_store_i;
                xlate_o.invalid_store = xlate_hit && !hit_half.valid && access_store_i;
                xlate_o.write_protect = xlate_hit && hit_half.valid && access_store_i && !hit_half.dirty;
            end
        end
    end

    // Next state of all registers, buffer entries included.
    always_comb begin
        state_next = state_reg;
        state_next.read_valid = 1'b0;

        // decrement within bounds
        // Wrapping at the boundary keeps protected slots safe.
        if (instr_retire_i) begin
            if (state_reg.replace_pointer <= state_reg.boundary) begin
                state_next.replace_pointer = REPLACE_UPPER;
            end else begin
                state_next.replace_pointer = state_reg.replace_pointer - 5'h01;
            end
        end

        // Register writes; reserved bits are dropped so they read as zero.
        if (reg_write_i) begin
            case (reg_num_i)
                REG_SLOT_POINTER: begin
                    // slot field write
                    // The probe flag is kept, so software cannot forge it.
                    state_next.slot_pointer = (reg_wdata_i & SLOT_WR_MASK) |
                                              {state_reg.slot_pointer[PROBE_FAIL_BIT], 31'h0};
                end
                REG_EVEN_ENTRY_LOW: state_next.even_entry_low = reg_wdata_i & LO_WR_MASK;
                REG_ODD_ENTRY_LOW: state_next.odd_entry_low = reg_wdata_i & LO_WR_MASK;
                REG_BOUNDARY: begin
                    state_next.boundary = reg_wdata_i[4:0];
                    state_next.replace_pointer = REPLACE_UPPER;
                end
                default: begin
                    state_next.boundary = state_next.boundary;
                end
            endcase
        end

        // Instructions come after register writes, so they win a clash.
        // probe result flag
        if (probe_instruction_i) begin
            if (probe_hit) begin
                state_next.slot_pointer = {27'h0, probe_slot};
            end else begin
                state_next.slot_pointer[PROBE_FAIL_BIT] = 1'b1;
            end
        end

        if (indexed_read_instruction_i) begin
            state_next.even_entry_low = half_to_low(state_reg.entry[state_reg.slot_pointer[SLOT_W-1:0]].half[0],
                                                    state_reg.entry[state_reg.slot_pointer[SLOT_W-1:0]].global_page);
            state_next.odd_entry_low = half_to_low(state_reg.entry[state_reg.slot_pointer[SLOT_W-1:0]].half[1],
                                                   state_reg.entry[state_reg.slot_pointer[SLOT_W-1:0]].global_page);
            state_next.read_high = state_reg.entry[state_reg.slot_pointer[SLOT_W-1:0]].high;
        end

        if (indexed_write_instruction_i) begin
            state_next.entry[state_reg.slot_pointer[SLOT_W-1:0]] = new_entry;
        end

        if (random_write_instruction_i) begin
            state_next.entry[state_reg.replace_pointer] = new_entry;
        end

        // Register reads answer one cycle later from the read data flip-flops.
        if (reg_read_i) begin
            state_next.read_valid = 1'b1;
            case (reg_num_i)
                REG_SLOT_POINTER: state_next.read_data = state_reg.slot_pointer;
                REG_REPLACE_POINTER: state_next.read_data = {27'h0, state_reg.replace_pointer};
                REG_EVEN_ENTRY_LOW: state_next.read_data = state_reg.even_entry_low;
                REG_ODD_ENTRY_LOW: state_next.read_data = state_reg.odd_entry_low;
                REG_BOUNDARY: state_next.read_data = {27'h0, state_reg.boundary};
                default: state_next.read_data = 32'h0000_0000;
            endcase
        end
    end

    // software initialises contents
    // Reset clears everything for determinism; only the replacement pointer and the boundary have set values.
    // Software must still load the cleared registers before use.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.replace_pointer <= REPLACE_RESET;
            state_reg.boundary <= BOUNDARY_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Register port answer and indexed read upper half.
    assign reg_rdata_o = state_reg.read_data;
    assign reg_rvalid_o = state_reg.read_valid;
    assign read_high_o = state_reg.read_high;

endmodule : kernel_segment_decode_tlb_regs

`default_nettype wire

// [verification/pipeline_model.sv]
// Behavioural pipeline that retires instructions toward the translation registers.
`timescale 1ns/1ps
`default_nettype none
module pipeline_model (
    // Clock and retire strobe.
    input wire logic clk_sys_i,
    output logic instr_retire_o
);
    // Idle until the bench asks for retirements.
    initial instr_retire_o = 1'h0;
    // Gives n one-cycle retire pulses, each followed by gap plus one idle cycles.
    task automatic retire(input int n, input int gap);
        repeat (n) begin
            @(posedge clk_sys_i) #1;
            instr_retire_o = 1'h1;
            @(posedge clk_sys_i) #1;
            instr_retire_o = 1'h0;
            repeat (gap) @(posedge clk_sys_i) #1;
        end
    endtask : retire
endmodule : pipeline_model
`default_nettype wire

// [verification/kseg_tlb_props.sv]
// Concurrent checks for the segment decoder and register port.
`timescale 1ns/1ps
`default_nettype none
module kseg_tlb_props
    import kseg_tlb_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Status and address.
    input wire logic wide_kernel_addressing_i,
    input wire logic error_level_flag_i,
    input wire logic [2:0] kernel_window_cache_algo_i,
    input wire logic [63:0] vaddr_i,
    // Register port and result.
    input wire logic reg_read_i,
    input wire logic [4:0] reg_num_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire xlate_s xlate_o
);
    // Mode and window helpers.
    wire logic k32 = !wide_kernel_addressing_i;
    wire logic w64 = wide_kernel_addressing_i;
    wire logic compat = w64 && (&vaddr_i[63:31]);
    wire logic phys = w64 && (vaddr_i[63:62] == REGION_PHYS);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    upper_win_a: assert property (k32 && vaddr_i[31:30] == 2'h3 |-> xlate_o.mapped)
        else $error("upper 32-bit window not mapped");
    wide_user_a: assert property (w64 && !error_level_flag_i && !vaddr_i[63] && vaddr_i[61:40] == 22'h0
        |-> xlate_o.mapped && !xlate_o.addr_error) else $error("wide user or supervisor window wrong");
    error_direct_a: assert property (error_level_flag_i && k32 && !vaddr_i[31]
        |-> !xlate_o.mapped && !xlate_o.cached && xlate_o.paddr == vaddr_i[31:0]) else $error("error level decode wrong");
    phys_error_a: assert property (phys |-> !xlate_o.mapped && xlate_o.addr_error == (|vaddr_i[58:32]))
        else $error("physical window error flag wrong");
    phys_cache_a: assert property (phys && !(|vaddr_i[58:32])
        |-> xlate_o.cached == (vaddr_i[61:59] != 3'h2) && xlate_o.paddr == vaddr_i[31:0]) else $error("physical window cache wrong");
    kernel_map_a: assert property (w64 && vaddr_i[63:62] == REGION_KERNEL && vaddr_i[61:40] == 22'h0
        && !(&vaddr_i[39:31]) |-> xlate_o.mapped) else $error("kernel space not mapped");
    compat_zero_a: assert property (compat && vaddr_i[30:29] == 2'h0
        |-> !xlate_o.mapped && xlate_o.cached == (kernel_window_cache_algo_i != ALGO_UNCACHED)) else $error("compat zero wrong");
    compat_one_a: assert property (compat && vaddr_i[30:29] == 2'h1 |-> !xlate_o.mapped && !xlate_o.cached)
        else $error("compat one not unmapped uncached");
    compat_map_a: assert property (compat && vaddr_i[30] |-> xlate_o.mapped)
        else $error("upper compat window not mapped");
    slot_read_a: assert property (reg_read_i && reg_num_i == REG_SLOT_POINTER
        |=> reg_rvalid_o && reg_rdata_o[30:5] == 26'h0) else $error("slot pointer read wrong");
    replace_read_a: assert property (reg_read_i && reg_num_i == REG_REPLACE_POINTER
        |=> reg_rvalid_o && reg_rdata_o[31:5] == 27'h0) else $error("replacement read wrong");
    // Main scenarios seen.
    cover property (reg_rvalid_o);
    cover property (compat && vaddr_i[30:29] == 2'h1);
    cover property (xlate_o.addr_error);
endmodule : kseg_tlb_props
bind kernel_segment_decode_tlb_regs kseg_tlb_props kseg_tlb_props_inst (.clk_sys_i, .resetn_i,
    .wide_kernel_addressing_i, .error_level_flag_i, .kernel_window_cache_algo_i, .vaddr_i,
    .reg_read_i, .reg_num_i, .reg_rdata_o, .reg_rvalid_o, .xlate_o);
`default_nettype wire

// [verification/kernel_segment_decode_tlb_regs_bench.sv]
// Self-checking bench for the kernel segment decoder and translation registers.
`timescale 1ns/1ps
`default_nettype none
module kernel_segment_decode_tlb_regs_bench import kseg_tlb_pkg::*; ;
    typedef struct packed {
        logic [4:0] mode;
        logic [63:0] va;
        logic [2:0] res;
        logic [31:0] pa;
    } row_s;
    logic clk_sys_i, resetn_i, wide, level, valid, store, retire, wr_en, rd_en, rvalid, rwr;
    logic [2:0] algo, ins;
    logic [63:0] vaddr;
    logic [7:0] sid;
    logic [4:0] num;
    logic [31:0] wdata, rdata;
    entry_high_s ehi, rhigh;
    xlate_s xlate_o;
    int failures, checks, cycles;
    // Decode rows: mode is wide, level, algo; res is mapped, cached, error.
    row_s rows [15] = '{'{5'h00, 64'hffff_ffff_c000_0010, 3'h4, 32'h0}, '{5'h00, 64'hffff_ffff_e000_0000, 3'h4, 32'h0},
        '{5'h08, 64'h0000_0000_1234_5678, 3'h0, 32'h1234_5678}, '{5'h10, 64'h0000_0000_8000_0000, 3'h4, 32'h0},
        '{5'h10, 64'h4000_0000_0000_0000, 3'h4, 32'h0}, '{5'h10, 64'h8000_0001_0000_0000, 3'h1, 32'h0},
        '{5'h10, 64'h9000_0000_89ab_cdef, 3'h0, 32'h89ab_cdef}, '{5'h10, 64'hb800_0000_0000_0040, 3'h2, 32'h40},
        '{5'h12, 64'hffff_ffff_8000_1000, 3'h0, 32'h1000}, '{5'h13, 64'hffff_ffff_8000_1000, 3'h2, 32'h1000},
        '{5'h13, 64'hffff_ffff_a000_0020, 3'h0, 32'h20}, '{5'h10, 64'hffff_ffff_c000_0000, 3'h4, 32'h0},
        '{5'h10, 64'hc000_0000_0000_0000, 3'h4, 32'h0}, '{5'h18, 64'h0000_0000_7654_3210, 3'h0, 32'h7654_3210},
        '{5'h10, 64'h0000_0100_0000_0000, 3'h1, 32'h0}};

    kernel_segment_decode_tlb_regs kernel_segment_decode_tlb_regs_inst (.clk_sys_i, .resetn_i,
        .wide_kernel_addressing_i(wide), .error_level_flag_i(level), .kernel_window_cache_algo_i(algo),
        .access_valid_i(valid), .access_store_i(store), .vaddr_i(vaddr), .space_identifier_i(sid),
        .probe_instruction_i(ins[0]), .indexed_read_instruction_i(ins[1]), .indexed_write_instruction_i(ins[2]),
        .random_write_instruction_i(rwr), .entry_high_i(ehi), .instr_retire_i(retire), .reg_num_i(num),
        .reg_write_i(wr_en), .reg_wdata_i(wdata), .reg_read_i(rd_en), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .read_high_o(rhigh), .xlate_o);
    pipeline_model pipeline_model_inst (.clk_sys_i, .instr_retire_o(retire));

    // Clock of 100 ns period.
    initial begin
        clk_sys_i = 1'h0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // Watchdog on the whole run.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic step;
        @(posedge clk_sys_i) #1;
    endtask : step

    task automatic wr(input logic [4:0] n, input logic [31:0] d);
        num = n;
        wdata = d;
        wr_en = 1'h1;
        step();
        wr_en = 1'h0;
        step();
    endtask : wr

    task automatic rd(input logic [4:0] n, input logic [31:0] e);
        num = n;
        rd_en = 1'h1;
        step();
        rd_en = 1'h0;
        chk(64'({rvalid, rdata}), 64'({1'h1, e}));
        step();
    endtask : rd

    task automatic op(input logic [2:0] v);
        ins = v;
        step();
        ins = 3'h0;
        step();
    endtask : op

    task automatic close_out;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Main sequence.
    initial begin
        {resetn_i, wide, level, valid, store, wr_en, rd_en, rwr} = 8'h0;
        {algo, ins, vaddr, sid, num, wdata, ehi} = '0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk(64'({rvalid, rdata}), 64'h0);
        resetn_i = 1'h1;
        rd(REG_REPLACE_POINTER, 32'h1f);
        rd(REG_BOUNDARY, 32'h0);
        rd(5'h09, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 15; i++) begin
            {wide, level, algo} = rows[i].mode;
            vaddr = rows[i].va;
            step();
            chk(64'({xlate_o.mapped, xlate_o.addr_error}), 64'({rows[i].res[2], rows[i].res[0]}));
            if (rows[i].res == 3'h0 || rows[i].res == 3'h2)
                chk(64'({xlate_o.cached, xlate_o.paddr}), 64'({rows[i].res[1], rows[i].pa}));
        end
        $display("decode table done");
        // Replacement pointer counts down, reloads 31 on boundary writes, wraps at the boundary and ignores writes.
        pipeline_model_inst.retire(3, 0);
        rd(REG_REPLACE_POINTER, 32'h1c);
        wr(REG_BOUNDARY, 32'h5);
        rd(REG_REPLACE_POINTER, 32'h1f);
        wr(REG_BOUNDARY, 32'h1e);
        wr(REG_REPLACE_POINTER, 32'h0);
        pipeline_model_inst.retire(2, 2);
        rd(REG_REPLACE_POINTER, 32'h1f);
        rd(REG_BOUNDARY, 32'h1e);
        $display("replacement test done");
        wr(REG_SLOT_POINTER, 32'h3);
        wr(REG_EVEN_ENTRY_LOW, 32'h5b);
        wr(REG_ODD_ENTRY_LOW, 32'h95);
        ehi = '{REGION_USER, 29'h2468a, 8'h00};
        op(3'h4);
        {wide, level, valid, store, sid, vaddr} = {4'hb, 8'h55, 64'h1234_5000};
        step();
        chk(64'({xlate_o.mapped, xlate_o.cached, xlate_o.write_protect, xlate_o.paddr}), 64'({3'h7, 32'h400}));
        for (int s = 0; s < 2; s++) begin
            {store, vaddr} = {s[0], 64'h1234_5400};
            step();
            chk(64'({xlate_o.tlb_refill, xlate_o.invalid_load, xlate_o.invalid_store}), 64'({1'h0, !s[0], s[0]}));
        end
        ehi.vpn2 = 29'h1;
        op(3'h1);
        rd(REG_SLOT_POINTER, 32'h8000_0003);
        ehi.vpn2 = 29'h2468a;
        op(3'h1);
        rd(REG_SLOT_POINTER, 32'h3);
        wr(REG_EVEN_ENTRY_LOW, 32'h0);
        op(3'h2);
        rd(REG_EVEN_ENTRY_LOW, 32'h5b);
        rd(REG_ODD_ENTRY_LOW, 32'h95);
        chk(64'(rhigh), 64'(ehi));
        ehi.vpn2 = 29'h7;
        vaddr = 64'h3800;
        step();
        chk(64'(xlate_o.tlb_refill), 64'h1);
        rwr = 1'h1;
        step();
        rwr = 1'h0;
        chk(64'({xlate_o.tlb_refill, xlate_o.paddr}), 64'({1'h0, 32'h400}));
        op(3'h1);
        rd(REG_SLOT_POINTER, 32'h1f);
        $display("translation test done");
        resetn_i = 1'h0;
        step();
        resetn_i = 1'h1;
        rd(REG_BOUNDARY, 32'h0);
        $display("second reset test done");
        close_out();
    end
endmodule : kernel_segment_decode_tlb_regs_bench
`default_nettype wire
